// ===== vbt_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "vbt_regs.svh"
module vbt_core
  import vbt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clkEn,
  // register port
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // overvoltage comparator levels
  input wire logic dataLineOv,
  input wire logic busSupplyOv,
  input wire logic configChanOv,
  // internal count source when the device owns the counter
  input wire logic [10:0] internalCount,
  // feedback current pin control
  output logic fbSource,
  output logic fbSink,
  output logic [10:0] fbMagnitude,
  output logic [10:0] stepCountOut
);

  vbt_state_t s_q;
  vbt_state_t s_d;
  logic wrCtrl;
  logic wrLo;
  logic wrHi;
  logic rdStat;
  logic [2:0] ovEvents;
  logic [10:0] nextCount;

  // access decode
  assign wrCtrl = regWr && (regAddr == `VBT_ADDR_CTRL);
  assign wrLo = regWr && (regAddr == `VBT_ADDR_CNTLO);
  assign wrHi = regWr && (regAddr == `VBT_ADDR_CNTHI);
  assign rdStat = regRd && (regAddr == `VBT_ADDR_OVSTAT);
  assign ovEvents = {dataLineOv, busSupplyOv, configChanOv};

  // next state
  always_comb
  begin
    s_d = s_q;
    nextCount = s_q.stepCount;
    // read clears flags, but a live event in the same cycle wins
    if (rdStat)
    begin
      s_d.ovFlags = `VBT_FLAGS_CLR;
    end
    s_d.ovFlags = s_d.ovFlags | ovEvents;
    if (regWr)
    begin
      unique case (regAddr)
        `VBT_ADDR_CTRL: s_d.owner = regWdata[`VBT_BIT_OWNER];
        `VBT_ADDR_CNTLO: s_d.cntLo = regWdata;
        `VBT_ADDR_CNTHI:
        begin
          s_d.cntHi = regWdata[`VBT_FLD_CNTHI];
          s_d.hiSpare = regWdata[`VBT_FLD_SPARE];
        end
        `VBT_ADDR_FWHI: s_d.fwHi = regWdata;
        `VBT_ADDR_FWLO: s_d.fwLo = regWdata;
        `VBT_ADDR_HWREV: s_d.hwSpare = regWdata[`VBT_FLD_HWSPARE];
        default: s_d.hwSpare = s_d.hwSpare;
      endcase
    end
    // apply the target on a one written to the apply bit
    if (wrHi && regWdata[`VBT_BIT_APPLY] && s_q.owner)
    begin
      nextCount = {regWdata[`VBT_FLD_CNTHI], s_q.cntLo};
    end
    if (!s_q.owner)
    begin
      nextCount = internalCount;
    end
    // restore beats everything else; bit never stored so reads zero
    if (wrCtrl && regWdata[`VBT_BIT_RESTORE])
    begin
      s_d.cntLo = `VBT_RST_CNTLO;
      s_d.cntHi = `VBT_RST_CNTHI;
      s_d.hiSpare = `VBT_SPARE_CLR;
      nextCount = `VBT_CNT_DEFAULT;
    end
    s_d.stepCount = nextCount;
    // feedback pin direction and magnitude
    if (nextCount == `VBT_CNT_DEFAULT)
    begin
      s_d.fbSrc = 1'b0;
      s_d.fbSnk = 1'b0;
      s_d.fbMag = `VBT_MAG_ZERO;
    end
    else if (nextCount < `VBT_CNT_DEFAULT)
    begin
      s_d.fbSrc = 1'b1;
      s_d.fbSnk = 1'b0;
      s_d.fbMag = `VBT_CNT_DEFAULT - nextCount;
    end
    else
    begin
      s_d.fbSrc = 1'b0;
      s_d.fbSnk = 1'b1;
      s_d.fbMag = nextCount - `VBT_CNT_DEFAULT;
    end
    // read data, registered
    unique case (regAddr)
      `VBT_ADDR_OVSTAT: s_d.rdata = {5'h00, s_q.ovFlags};
      `VBT_ADDR_CTRL: s_d.rdata = {7'h00, s_q.owner};
      `VBT_ADDR_CNTLO: s_d.rdata = s_q.cntLo;
      `VBT_ADDR_CNTHI: s_d.rdata = {1'b0, s_q.hiSpare, 2'h0, s_q.cntHi};
      `VBT_ADDR_FWHI: s_d.rdata = s_q.fwHi;
      `VBT_ADDR_FWLO: s_d.rdata = s_q.fwLo;
      `VBT_ADDR_HWREV: s_d.rdata = {`VBT_HW_REV, s_q.hwSpare};
      default: s_d.rdata = 8'h00;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '{ovFlags: `VBT_FLAGS_CLR,
               owner: 1'b0,
               cntLo: `VBT_RST_CNTLO,
               cntHi: `VBT_RST_CNTHI,
               hiSpare: `VBT_SPARE_CLR,
               stepCount: `VBT_CNT_DEFAULT,
               fwHi: `VBT_RST_BYTE,
               fwLo: `VBT_RST_BYTE,
               hwSpare: 3'h0,
               rdata: `VBT_RST_BYTE,
               fbSrc: 1'b0,
               fbSnk: 1'b0,
               fbMag: `VBT_MAG_ZERO};
    end
    else if (clkEn)
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign regRdata = s_q.rdata;
  assign fbSource = s_q.fbSrc;
  assign fbSink = s_q.fbSnk;
  assign fbMagnitude = s_q.fbMag;
  assign stepCountOut = s_q.stepCount;

  // checks
  restore_count_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && wrCtrl && regWdata[`VBT_BIT_RESTORE]
      |=> stepCountOut == `VBT_CNT_DEFAULT && !fbSource && !fbSink)
    else $error("restore did not return count to default");
  restore_bytes_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && wrCtrl && regWdata[`VBT_BIT_RESTORE]
      |=> s_q.cntLo == `VBT_RST_CNTLO && s_q.cntHi == `VBT_RST_CNTHI)
    else $error("restore did not reset target bytes");
  flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && dataLineOv |=> s_q.ovFlags[2])
    else $error("data-line flag not set");
  supply_set_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && busSupplyOv |=> s_q.ovFlags[1])
    else $error("supply flag not set");
  cc_set_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && configChanOv |=> s_q.ovFlags[0])
    else $error("config channel flag not set");
  read_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && rdStat && ovEvents == `VBT_FLAGS_CLR |=> s_q.ovFlags == `VBT_FLAGS_CLR)
    else $error("status read did not clear flags");
  flag_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && !rdStat && s_q.ovFlags[2] |=> s_q.ovFlags[2])
    else $error("flag dropped without a read");
  source_dir_a: assert property (@(posedge clk) disable iff (!nrst)
    stepCountOut < `VBT_CNT_DEFAULT
      |-> fbSource && fbMagnitude == `VBT_CNT_DEFAULT - stepCountOut)
    else $error("source current wrong below default");
  sink_dir_a: assert property (@(posedge clk) disable iff (!nrst)
    stepCountOut > `VBT_CNT_DEFAULT
      |-> fbSink && fbMagnitude == stepCountOut - `VBT_CNT_DEFAULT)
    else $error("sink current wrong above default");
  idle_dir_a: assert property (@(posedge clk) disable iff (!nrst)
    stepCountOut == `VBT_CNT_DEFAULT
      |-> !fbSink && !fbSource && fbMagnitude == `VBT_MAG_ZERO)
    else $error("current driven at default count");
  apply_only_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && s_q.owner && $past(s_q.owner) && !wrHi && !wrCtrl |=> $stable(stepCountOut))
    else $error("count changed without apply");
  apply_take_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && s_q.owner && wrHi && regWdata[`VBT_BIT_APPLY] && !wrCtrl
      |=> stepCountOut == {$past(regWdata[`VBT_FLD_CNTHI]), $past(s_q.cntLo)})
    else $error("apply did not load target");
  owner_int_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && !s_q.owner && !wrCtrl |=> stepCountOut == $past(internalCount))
    else $error("internal owner not followed");
  fw_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && regWr && regAddr == `VBT_ADDR_FWHI |=> s_q.fwHi == $past(regWdata))
    else $error("firmware byte not stored");

  // a frozen enable holds the count
  freeze_count_a: assert property (@(posedge clk) disable iff (!nrst)
    !clkEn |=> $stable(stepCountOut))
    else $error("count moved while frozen");

  // a frozen enable holds the read data
  freeze_rdata_a: assert property (@(posedge clk) disable iff (!nrst)
    !clkEn |=> $stable(regRdata))
    else $error("read data moved while frozen");

  // a frozen enable holds the flags
  freeze_flags_a: assert property (@(posedge clk) disable iff (!nrst)
    !clkEn |=> $stable(s_q.ovFlags))
    else $error("flags moved while frozen");

  // never source and sink at once
  dir_excl_a: assert property (@(posedge clk) disable iff (!nrst)
    !(fbSource && fbSink))
    else $error("source and sink both on");

  // a driven pin always has a magnitude
  mag_nonzero_a: assert property (@(posedge clk) disable iff (!nrst)
    fbSource || fbSink |-> fbMagnitude != `VBT_MAG_ZERO)
    else $error("drive with zero magnitude");

  // most source current at count zero
  source_most_a: assert property (@(posedge clk) disable iff (!nrst)
    stepCountOut == `VBT_CNT_MIN |-> fbSource && fbMagnitude == `VBT_CNT_DEFAULT)
    else $error("source magnitude wrong at zero");

  // most sink current at full count
  sink_most_a: assert property (@(posedge clk) disable iff (!nrst)
    stepCountOut == `VBT_CNT_FULL |-> fbMagnitude == `VBT_CNT_FULL - `VBT_CNT_DEFAULT)
    else $error("sink magnitude wrong at full");

  // magnitude never exceeds the sink span
  mag_bound_a: assert property (@(posedge clk) disable iff (!nrst)
    fbMagnitude <= `VBT_CNT_FULL - `VBT_CNT_DEFAULT)
    else $error("magnitude out of range");

  // low target byte stored on write
  lo_store_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && wrLo |=> s_q.cntLo == $past(regWdata))
    else $error("low target byte not stored");

  // high target bits stored on write
  hi_store_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && wrHi |=> s_q.cntHi == $past(regWdata[`VBT_FLD_CNTHI]))
    else $error("high target bits not stored");

  // spare high bits stored on write
  spare_store_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && wrHi |=> s_q.hiSpare == $past(regWdata[`VBT_FLD_SPARE]))
    else $error("spare bits not stored");

  // restore clears the spare high bits too
  restore_spare_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && wrCtrl && regWdata[`VBT_BIT_RESTORE] |=> s_q.hiSpare == `VBT_SPARE_CLR)
    else $error("restore left spare bits");

  // owner bit stored on control write
  owner_store_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && wrCtrl |=> s_q.owner == $past(regWdata[`VBT_BIT_OWNER]))
    else $error("owner bit not stored");

  // lower firmware byte stored on write
  fwlo_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && regWr && regAddr == `VBT_ADDR_FWLO |=> s_q.fwLo == $past(regWdata))
    else $error("lower firmware byte not stored");

  // upper firmware byte kept without a write
  fw_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && !(regWr && regAddr == `VBT_ADDR_FWHI) |=> $stable(s_q.fwHi))
    else $error("firmware byte changed unasked");

  // revision spare bits stored on write
  rev_store_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && regWr && regAddr == `VBT_ADDR_HWREV
      |=> s_q.hwSpare == $past(regWdata[`VBT_FLD_HWSPARE]))
    else $error("revision spare not stored");

  // supply flag held until read
  supply_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && !rdStat && s_q.ovFlags[`VBT_BIT_BSOV] |=> s_q.ovFlags[`VBT_BIT_BSOV])
    else $error("supply flag dropped without a read");

  // config-channel flag held until read
  cc_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && !rdStat && s_q.ovFlags[`VBT_BIT_CCOV] |=> s_q.ovFlags[`VBT_BIT_CCOV])
    else $error("config channel flag dropped without a read");

  // status read returns the flags before clearing
  flag_read_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && regAddr == `VBT_ADDR_OVSTAT |=> regRdata == {5'h00, $past(s_q.ovFlags)})
    else $error("status read data wrong");

  // restore bit always reads zero
  restore_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && regAddr == `VBT_ADDR_CTRL |=> !regRdata[`VBT_BIT_RESTORE])
    else $error("restore bit read as one");

  // control read returns the owner
  ctrl_read_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && regAddr == `VBT_ADDR_CTRL |=> regRdata == {7'h00, $past(s_q.owner)})
    else $error("control read data wrong");

  // apply bit always reads zero
  apply_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && regAddr == `VBT_ADDR_CNTHI |=> !regRdata[`VBT_BIT_APPLY])
    else $error("apply bit read as one");

  // high byte read returns the count bits
  hi_read_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && regAddr == `VBT_ADDR_CNTHI |=> regRdata[`VBT_FLD_CNTHI] == $past(s_q.cntHi))
    else $error("high byte read data wrong");

  // low byte read returns the stored byte
  lo_read_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && regAddr == `VBT_ADDR_CNTLO |=> regRdata == $past(s_q.cntLo))
    else $error("low byte read data wrong");

  // upper firmware read returns the stored byte
  fw_read_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && regAddr == `VBT_ADDR_FWHI |=> regRdata == $past(s_q.fwHi))
    else $error("firmware read data wrong");

  // revision field reads the fixed code
  rev_read_a: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && regAddr == `VBT_ADDR_HWREV |=> regRdata[`VBT_FLD_HWREV] == `VBT_HW_REV)
    else $error("revision field wrong");

  cover_restore: cover property (@(posedge clk) clkEn && wrCtrl && regWdata[`VBT_BIT_RESTORE]);
  cover_apply: cover property (@(posedge clk) clkEn && s_q.owner && wrHi
    && regWdata[`VBT_BIT_APPLY]);
  cover_sink_full: cover property (@(posedge clk) stepCountOut == `VBT_CNT_FULL);
  cover_freeze: cover property (@(posedge clk) !clkEn && nrst);
  cover_read_flag: cover property (@(posedge clk) rdStat && s_q.ovFlags != 3'h0);

endmodule : vbt_core
`default_nettype wire

// ===== vbt_regs.svh
`ifndef VBT_REGS_SVH
`define VBT_REGS_SVH
// register offsets
`define VBT_ADDR_OVSTAT 8'hCD
`define VBT_ADDR_CTRL 8'hD0
`define VBT_ADDR_CNTLO 8'hD1
`define VBT_ADDR_CNTHI 8'hD2
`define VBT_ADDR_FWHI 8'hDD
`define VBT_ADDR_FWLO 8'hDE
`define VBT_ADDR_HWREV 8'hDF
// field positions
`define VBT_BIT_RESTORE 7
`define VBT_BIT_OWNER 0
`define VBT_BIT_APPLY 7
`define VBT_BIT_DLOV 2
`define VBT_BIT_BSOV 1
`define VBT_BIT_CCOV 0
`define VBT_FLD_CNTHI 2:0
`define VBT_FLD_SPARE 6:5
`define VBT_FLD_HWREV 7:3
`define VBT_FLD_HWSPARE 2:0
// reset values and count limits
`define VBT_RST_CNTLO 8'hC8
`define VBT_RST_CNTHI 3'h0
`define VBT_RST_BYTE 8'h00
`define VBT_CNT_DEFAULT 11'h0C8
`define VBT_CNT_FULL 11'h7FF
`define VBT_CNT_MIN 11'h000
`define VBT_MAG_ZERO 11'h000
`define VBT_FLAGS_CLR 3'h0
`define VBT_SPARE_CLR 2'h0
// arbitrary neutral silicon revision code
`define VBT_HW_REV 5'h03
`endif

// ===== vbt_pkg.sv
package vbt_pkg;
  typedef struct packed {
    logic [2:0] ovFlags;
    logic owner;
    logic [7:0] cntLo;
    logic [2:0] cntHi;
    logic [1:0] hiSpare;
    logic [10:0] stepCount;
    logic [7:0] fwHi;
    logic [7:0] fwLo;
    logic [2:0] hwSpare;
    logic [7:0] rdata;
    logic fbSrc;
    logic fbSnk;
    logic [10:0] fbMag;
  } vbt_state_t;
endpackage : vbt_pkg

// ===== vbt_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module vbt_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic regWr,
  output logic regRd,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial {regWr, regRd, regAddr, regWdata} = '0;
  // one write cycle; data is scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {regWr, regAddr, regWdata} = {1'b1, a, d};
    @(negedge clk) {regWr, regWdata} = {1'b0, ~d};
  endtask : wr
  // one read cycle; data is registered on the sampling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk) {regRd, regAddr} = {1'b1, a};
    @(negedge clk) regRd = 1'b0;
    q = regRdata;
  endtask : rd
endmodule : vbt_host_model
`default_nettype wire

// ===== vbus_target_and_ov_status_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "vbt_regs.svh"
module vbus_target_and_ov_status_tb;
  logic clk = 0, nrst = 0, dlOv = 0, bsOv = 0, ccOv = 0, regWr, regRd, fbSrc, fbSnk;
  logic clkEn = 1;
  logic [7:0] regAddr, regWdata, regRdata, q;
  logic [10:0] intCnt = 11'h0C8, fbMag, stepCnt, n;
  int errCount = 0, checked = 0, cyc = 0;
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  vbt_host_model vbt_host_model_i (.clk(clk), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  vbt_core vbt_core_i (.clk(clk), .nrst(nrst), .clkEn(clkEn), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .dataLineOv(dlOv),
    .busSupplyOv(bsOv), .configChanOv(ccOv), .internalCount(intCnt), .fbSource(fbSrc),
    .fbSink(fbSnk), .fbMagnitude(fbMag), .stepCountOut(stepCnt));
  // compare and count
  task automatic chk(input logic [12:0] s, input logic [12:0] e);
    checked++;
    if (s !== e)
    begin
      errCount++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    vbt_host_model_i.rd(a, q);
    chk({5'h00, q}, {5'h00, e});
  endtask : rdChk
  // expected direction and magnitude for a count
  function automatic logic [12:0] fbExp(input logic [10:0] c);
    if (c < `VBT_CNT_DEFAULT) return {2'b10, `VBT_CNT_DEFAULT - c};
    if (c > `VBT_CNT_DEFAULT) return {2'b01, c - `VBT_CNT_DEFAULT};
    return 13'h0000;
  endfunction : fbExp
  // host target write, apply bit optional
  task automatic setCnt(input logic [10:0] c, input logic ap);
    vbt_host_model_i.wr(`VBT_ADDR_CNTLO, c[7:0]);
    vbt_host_model_i.wr(`VBT_ADDR_CNTHI, {ap, 4'h0, c[10:8]});
    repeat (2) @(negedge clk);
  endtask : setCnt
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errCount++;
      finish_test();
    end
  end
  // main sequence
  initial
  begin
    void'($urandom(18535));
    repeat (16) @(negedge clk);
    nrst = 1;
    rdChk(`VBT_ADDR_CNTLO, `VBT_RST_CNTLO);
    rdChk(`VBT_ADDR_CNTHI, 8'h00);
    rdChk(`VBT_ADDR_HWREV, {`VBT_HW_REV, 3'h0});
    rdChk(8'hE0, 8'h00);
    chk({fbSrc, fbSnk, fbMag}, 13'h0000);
    for (int i = 0; i < 2; i++)
    begin
      n = 11'($urandom);
      vbt_host_model_i.wr(`VBT_ADDR_FWHI + 8'(i), n[7:0]);
      rdChk(`VBT_ADDR_FWHI + 8'(i), n[7:0]);
    end
    $display("reset and version test done");
    vbt_host_model_i.wr(`VBT_ADDR_CTRL, 8'h01);
    for (int i = 0; i < 9; i++)
    begin
      n = (i == 0) ? 11'h000 : (i == 1) ? 11'h0C8 : (i == 2) ? 11'h7FE : 11'($urandom) & 11'h7FE;
      setCnt(n, 1'b1);
      chk({2'b00, stepCnt}, {2'b00, n});
      chk({fbSrc, fbSnk, fbMag}, fbExp(n));
    end
    setCnt(11'h064, 1'b0);
    chk({2'b00, stepCnt}, {2'b00, n});
    $display("host count test done");
    vbt_host_model_i.wr(`VBT_ADDR_CTRL, 8'h81);
    rdChk(`VBT_ADDR_CTRL, 8'h01);
    rdChk(`VBT_ADDR_CNTLO, `VBT_RST_CNTLO);
    rdChk(`VBT_ADDR_CNTHI, 8'h00);
    chk({2'b00, stepCnt}, {2'b00, `VBT_CNT_DEFAULT});
    $display("restore test done");
    vbt_host_model_i.wr(`VBT_ADDR_CTRL, 8'h00);
    @(negedge clk) intCnt = 11'($urandom) & 11'h7FE;
    repeat (3) @(negedge clk);
    chk({2'b00, stepCnt}, {2'b00, intCnt});
    chk({fbSrc, fbSnk, fbMag}, fbExp(intCnt));
    $display("internal owner test done");
    n = intCnt;
    @(negedge clk) clkEn = 0;
    intCnt = n ^ 11'h002;
    repeat (3) @(negedge clk);
    chk({2'b00, stepCnt}, {2'b00, n});
    clkEn = 1;
    repeat (2) @(negedge clk);
    chk({2'b00, stepCnt}, {2'b00, intCnt});
    $display("clock enable test done");
    for (int b = 0; b < 3; b++)
    begin
      @(negedge clk) {dlOv, bsOv, ccOv} = 3'b001 << b;
      @(negedge clk) {dlOv, bsOv, ccOv} = 3'b000;
      rdChk(`VBT_ADDR_OVSTAT, 8'h01 << b);
      rdChk(`VBT_ADDR_OVSTAT, 8'h00);
    end
    @(negedge clk) dlOv = 1;
    rdChk(`VBT_ADDR_OVSTAT, 8'h04);
    rdChk(`VBT_ADDR_OVSTAT, 8'h04);
    $display("status flag test done");
    finish_test();
  end
endmodule : vbus_target_and_ov_status_tb
`default_nettype wire
